// ==== rtl/csr_chip_select_reset_config.sv ====
// chip-select reset configuration, settings storage and select decode
// Operation
// - general pin-assign low bits reset to one
// - general pin-assign high bits from DATA7..1
// - general base/option reset to documented values
// - general byte lanes disabled, no select asserted
// - vector fetch at zero decoded by boot
// - boot pin-assign high bit resets to one
// - boot byte lanes reset to both bytes
// - boot pin-assign low bit from DATA0
// - boot base address resets to zero
// - boot block size resets to 1 Mbyte
// - boot option async, rw, 13 waits
// - boot byte lanes ones, general cleared
// - matched enabled async-mode select asserts with strobe
`timescale 1ns/100ps
module csr_chip_select_reset_config
  import csr_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic [csr_pkg::DATA_LINES-1:0] data_bus,
  input  wire logic                          cfg_write,
  input  wire csr_pkg::csr_target_t          cfg_target,
  input  wire logic [3:0]                    cfg_index,
  input  wire logic [csr_pkg::SET_W-1:0]     cfg_data,
  input  wire logic [csr_pkg::ADDR_W-1:0]    acc_addr,
  input  wire logic [2:0]                    acc_fc,
  input  wire logic                          acc_read,
  input  wire logic                          acc_upper,
  input  wire logic                          acc_lower,
  input  wire logic                          address_strobe_pin,
  input  wire logic                          data_strobe_pin,
  output logic [13:0]                        select_pin_assign_low,
  output logic [9:0]                         select_pin_assign_high,
  output logic [csr_pkg::NUM_GEN-1:0][15:0]  select_base_setting,
  output logic [csr_pkg::NUM_GEN-1:0][15:0]  select_option_setting,
  output logic [15:0]                        boot_select_base_setting,
  output logic [15:0]                        boot_select_option_setting,
  output logic [csr_pkg::NUM_GEN-1:0]        select_output,
  output logic                               boot_select_output
);
  import csr_pkg::*;

  logic [NUM_GEN-1:0][1:0] gen_pin;
  logic [1:0]              boot_pin;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [12:0] blk_mask(input logic [2:0] blk);
    unique case (blk)
      BLK_2K:   blk_mask = 13'h1fff;
      BLK_8K:   blk_mask = 13'h1ffc;
      BLK_16K:  blk_mask = 13'h1ff8;
      BLK_64K:  blk_mask = 13'h1fe0;
      BLK_128K: blk_mask = 13'h1fc0;
      BLK_256K: blk_mask = 13'h1f80;
      BLK_512K: blk_mask = 13'h1f00;
      BLK_1M:   blk_mask = 13'h1e00;
    endcase
  endfunction : blk_mask

  function automatic logic sel_match(input logic [1:0] pin, input logic [15:0] base,
                                     input logic [15:0] opt);
    logic [12:0] mask;
    logic [1:0]  lanes;
    logic [1:0]  rw;
    logic [1:0]  space;
    logic [2:0]  interrupt_level_match;
    logic        hit_addr;
    logic        hit_byte;
    logic        hit_rw;
    logic        hit_space;
    logic        strobe;
    mask      = blk_mask(base[BLK_MSB:BLK_LSB]);
    lanes     = opt[OPT_BYTE_H:OPT_BYTE_L];
    rw        = opt[OPT_RW_H:OPT_RW_L];
    space     = opt[OPT_SPACE_H:OPT_SPACE_L];
    interrupt_level_match       = opt[OPT_IPL_H:OPT_IPL_L];
    hit_addr  = ((acc_addr[ADDR_W-1:ADDR_CMP_LSB] ^ base[BASE_MSB:BASE_LSB]) & mask) == 13'h0000;
    // 8-bit port: any nonzero lane setting enables; 16-bit: one enabled lane must match an accessed byte
    hit_byte  = pin[0] ? ((lanes[1] & acc_upper) | (lanes[0] & acc_lower)) : (lanes != 2'h0);
    hit_rw    = (rw == RW_BOTH) | (acc_read ? rw == RW_READ : rw == RW_WRITE);
    unique case (space)
      SPACE_CPU:   hit_space = (acc_fc == FC_CPU) && (interrupt_level_match == 3'h0 || acc_addr[3:1] == interrupt_level_match);
      SPACE_USER:  hit_space = !acc_fc[2];
      SPACE_SUPER: hit_space = acc_fc[2] && acc_fc != FC_CPU;
      SPACE_ANY:   hit_space = acc_fc != FC_CPU;
    endcase
    strobe    = opt[OPT_STRB] ? data_strobe_pin : address_strobe_pin;
    // only asynchronous mode is decoded here
    sel_match = pin[1] && !opt[OPT_MODE] && hit_addr && hit_byte && hit_rw && hit_space && strobe;
  endfunction : sel_match

  // ----------------------------------------------------------------
  // pin assignment fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_GEN; i++)
      begin
        gen_pin[i] <= {data_bus[GEN_DATA_LINE[i]], PIN_LSB_RST};
      end
      boot_pin <= {BOOT_PIN_MSB_RST, data_bus[BOOT_DATA_LINE]};
    end
    else if (cfg_write && cfg_target == TGT_PIN)
    begin
      if (cfg_index == BOOT_IDX)
        boot_pin <= cfg_data[1:0];
      else if (cfg_index < BOOT_IDX)
        gen_pin[cfg_index] <= cfg_data[1:0];
    end
  end

  assign select_pin_assign_low  = {gen_pin[5], gen_pin[4], gen_pin[3], gen_pin[2], gen_pin[1], gen_pin[0],
                                   boot_pin};
  assign select_pin_assign_high = {gen_pin[10], gen_pin[9], gen_pin[8], gen_pin[7], gen_pin[6]};

  // ----------------------------------------------------------------
  // base and option settings
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_GEN; i++)
      begin
        select_base_setting[i]   <= GEN_BASE_RST;
        select_option_setting[i] <= GEN_OPT_RST;
      end
      boot_select_base_setting   <= BOOT_BASE_RST;
      boot_select_option_setting <= BOOT_OPT_RST;
    end
    else if (cfg_write && cfg_target == TGT_BASE)
    begin
      if (cfg_index == BOOT_IDX)
        boot_select_base_setting <= cfg_data;
      else if (cfg_index < BOOT_IDX)
        select_base_setting[cfg_index] <= cfg_data;
    end
    else if (cfg_write && cfg_target == TGT_OPTION)
    begin
      if (cfg_index == BOOT_IDX)
        boot_select_option_setting <= cfg_data;
      else if (cfg_index < BOOT_IDX)
        select_option_setting[cfg_index] <= cfg_data;
    end
  end

  // ----------------------------------------------------------------
  // select outputs, active high, one cycle after the strobe sample
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      select_output      <= '0;
      boot_select_output <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_GEN; i++)
      begin
        select_output[i] <= sel_match(gen_pin[i], select_base_setting[i], select_option_setting[i]);
      end
      boot_select_output <= sel_match(boot_pin, boot_select_base_setting, boot_select_option_setting);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_gen_pin_low;
    $past(!reset_n) |-> (gen_pin[0][0] && gen_pin[10][0]);
  endproperty
  a_gen_pin_low: assert property (p_gen_pin_low) else $error("general pin low bit not one");

  property p_gen_pin_high;
    $past(!reset_n) |-> (gen_pin[0][1] == $past(data_bus[1]) && gen_pin[10][1] == $past(data_bus[7]));
  endproperty
  a_gen_pin_high: assert property (p_gen_pin_high) else $error("general pin high bit not sampled");

  property p_gen_reset_val;
    $past(!reset_n) |-> (select_base_setting[3] == GEN_BASE_RST && select_option_setting[3] == GEN_OPT_RST);
  endproperty
  a_gen_reset_val: assert property (p_gen_reset_val) else $error("general settings reset wrong");

  property p_gen_disabled;
    (select_option_setting[0][OPT_BYTE_H:OPT_BYTE_L] == 2'h0) |=> !select_output[0];
  endproperty
  a_gen_disabled: assert property (p_gen_disabled) else $error("disabled select asserted");

  property p_boot_vector;
    (boot_select_base_setting == BOOT_BASE_RST && boot_select_option_setting == BOOT_OPT_RST && boot_pin[1]
     && acc_addr == 24'h000000 && acc_fc == FC_SUP_PROG && acc_read
     && acc_upper && acc_lower && address_strobe_pin) |=> boot_select_output;
  endproperty
  a_boot_vector: assert property (p_boot_vector) else $error("boot select missed vector fetch");

  property p_boot_pin;
    $past(!reset_n) |-> (boot_pin == {BOOT_PIN_MSB_RST, $past(data_bus[0])});
  endproperty
  a_boot_pin: assert property (p_boot_pin) else $error("boot pin field reset wrong");

  property p_boot_settings;
    $past(!reset_n) |-> (boot_select_option_setting[OPT_BYTE_H:OPT_BYTE_L] == 2'h3
                         && boot_select_base_setting[BLK_MSB:BLK_LSB] == BLK_1M
                         && boot_select_option_setting == BOOT_OPT_RST);
  endproperty
  a_boot_settings: assert property (p_boot_settings) else $error("boot settings reset wrong");

  property p_select_strobe;
    (|select_output || boot_select_output) |-> $past(address_strobe_pin || data_strobe_pin);
  endproperty
  a_select_strobe: assert property (p_select_strobe) else $error("select without strobe");

  property p_pin_hold;
    !(cfg_write && cfg_target == TGT_PIN) |=> $stable(select_pin_assign_low) && $stable(select_pin_assign_high);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin fields changed without write");

endmodule : csr_chip_select_reset_config

// ==== include/csr_pkg.sv ====
// chip-select reset configuration constants and types
package csr_pkg;

  localparam int NUM_GEN     = 11;
  localparam int SET_W       = 16;
  localparam int ADDR_W      = 24;
  localparam int DATA_LINES  = 8;

  // base setting: [15:3] base address (addr 23:11), [2:0] block size
  localparam int BASE_LSB    = 3;
  localparam int BASE_MSB    = 15;
  localparam int BLK_LSB     = 0;
  localparam int BLK_MSB     = 2;
  localparam int ADDR_CMP_LSB = 11;

  localparam logic [2:0] BLK_2K   = 3'h0;
  localparam logic [2:0] BLK_8K   = 3'h1;
  localparam logic [2:0] BLK_16K  = 3'h2;
  localparam logic [2:0] BLK_64K  = 3'h3;
  localparam logic [2:0] BLK_128K = 3'h4;
  localparam logic [2:0] BLK_256K = 3'h5;
  localparam logic [2:0] BLK_512K = 3'h6;
  localparam logic [2:0] BLK_1M   = 3'h7;

  // option setting field positions
  localparam int OPT_MODE    = 15;
  localparam int OPT_BYTE_H  = 14;
  localparam int OPT_BYTE_L  = 13;
  localparam int OPT_RW_H    = 12;
  localparam int OPT_RW_L    = 11;
  localparam int OPT_STRB    = 10;
  localparam int OPT_WAIT_H  = 9;
  localparam int OPT_WAIT_L  = 6;
  localparam int OPT_SPACE_H = 5;
  localparam int OPT_SPACE_L = 4;
  localparam int OPT_IPL_H   = 3;
  localparam int OPT_IPL_L   = 1;
  localparam int OPT_AUTOVECTOR_REQUEST    = 0;

  localparam logic [1:0] RW_READ     = 2'h1;
  localparam logic [1:0] RW_WRITE    = 2'h2;
  localparam logic [1:0] RW_BOTH     = 2'h3;
  localparam logic [1:0] SPACE_CPU   = 2'h0;
  localparam logic [1:0] SPACE_USER  = 2'h1;
  localparam logic [1:0] SPACE_SUPER = 2'h2;
  localparam logic [1:0] SPACE_ANY   = 2'h3;
  localparam logic [2:0] FC_CPU      = 3'h7;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;

  // reset values
  localparam logic [15:0] GEN_BASE_RST  = 16'h0000;  // base 0, 2 Kbyte
  localparam logic [15:0] GEN_OPT_RST   = 16'h0000;  // async, byte off, rw reserved, AS, no wait, CPU space
  localparam logic [15:0] BOOT_BASE_RST = 16'h0007;  // base 0, 1 Mbyte
  localparam logic [15:0] BOOT_OPT_RST  = 16'h7b70;  // both bytes, rw, AS, 13 waits, sup/user space
  localparam logic        PIN_LSB_RST   = 1'b1;
  localparam logic        BOOT_PIN_MSB_RST = 1'b1;
  localparam logic [2:0]  BOOT_DATA_LINE = 3'h0;

  // data line sampled for the upper pin-assign bit of each general select
  localparam logic [NUM_GEN-1:0][2:0] GEN_DATA_LINE =
    {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1};

  localparam logic [3:0] BOOT_IDX = 4'hb;

  typedef enum logic [1:0] {TGT_PIN, TGT_BASE, TGT_OPTION} csr_target_t;

endpackage : csr_pkg

// ==== bench/csr_strap_model.sv ====
// far-side model: reset strap drivers on the data lines
`timescale 1ns/100ps
module csr_strap_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] strap,
  output logic      [7:0] data_bus
);
  logic [7:0] noise;

  // released bus keeps changing so stale straps cannot match by luck
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      noise <= ~strap;
    else
      noise <= noise + 8'h3b;
  end

  assign data_bus = reset_n ? noise : strap;
endmodule : csr_strap_model

// ==== bench/csr_chip_select_reset_config_bench.sv ====
// self-checking bench for the chip-select reset configuration block
`timescale 1ns/100ps
module csr_chip_select_reset_config_bench;
  import csr_pkg::*;
  logic                           mclk;
  logic                           reset_n;
  logic [7:0]                     strap;
  logic [DATA_LINES-1:0]          data_bus;
  logic                           cfg_write;
  csr_target_t                    cfg_target;
  logic [3:0]                     cfg_index;
  logic [SET_W-1:0]               cfg_data;
  logic [ADDR_W-1:0]              acc_addr;
  logic [2:0]                     acc_fc;
  logic                           acc_read;
  logic                           acc_upper;
  logic                           acc_lower;
  logic                           as_pin;
  logic                           ds_pin;
  logic [13:0]                    pin_low;
  logic [9:0]                     pin_high;
  logic [NUM_GEN-1:0][15:0]       gen_base;
  logic [NUM_GEN-1:0][15:0]       gen_opt;
  logic [15:0]                    boot_base;
  logic [15:0]                    boot_opt;
  logic [NUM_GEN-1:0]             sel;
  logic                           boot_sel;
  int                             n_errors = 0;
  int                             cmp_count = 0;
  int                             cycles = 0;

  csr_strap_model i_csr_strap_model (.mclk(mclk), .reset_n(reset_n), .strap(strap), .data_bus(data_bus));

  csr_chip_select_reset_config i_csr_chip_select_reset_config (
    .mclk(mclk), .reset_n(reset_n), .data_bus(data_bus), .cfg_write(cfg_write),
    .cfg_target(cfg_target), .cfg_index(cfg_index), .cfg_data(cfg_data),
    .acc_addr(acc_addr), .acc_fc(acc_fc), .acc_read(acc_read), .acc_upper(acc_upper),
    .acc_lower(acc_lower), .address_strobe_pin(as_pin), .data_strobe_pin(ds_pin),
    .select_pin_assign_low(pin_low), .select_pin_assign_high(pin_high),
    .select_base_setting(gen_base), .select_option_setting(gen_opt),
    .boot_select_base_setting(boot_base), .boot_select_option_setting(boot_opt),
    .select_output(sel), .boot_select_output(boot_sel));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  function automatic logic [23:0] exp_pins(input logic [7:0] s);
    logic [23:0] v;
    v[1:0] = {1'b1, s[0]};
    for (int i = 0; i < NUM_GEN; i++)
      v[2*i+2 +: 2] = {s[GEN_DATA_LINE[i]], 1'b1};
    return v;
  endfunction : exp_pins

  task automatic do_reset(input logic [7:0] s);
    @(posedge mclk);
    strap   <= s;
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
  endtask : do_reset

  task automatic check_reset(input logic [7:0] s);
    chk({pin_high, pin_low}, exp_pins(s));
    chk(boot_base, {13'h0000, BLK_1M});
    chk(boot_opt, 16'h7b70);
    chk({sel, boot_sel}, 12'h000);
    for (int i = 0; i < NUM_GEN; i++)
    begin
      chk(gen_base[i], 16'h0000);
      chk(gen_opt[i], 16'h0000);
    end
  endtask : check_reset

  task automatic cfg_wr(input csr_target_t t, input logic [3:0] idx, input logic [15:0] d);
    @(posedge mclk);
    cfg_write  <= 1'b1;
    cfg_target <= t;
    cfg_index  <= idx;
    cfg_data   <= d;
    @(posedge mclk);
    cfg_write  <= 1'b0;
    #1;
  endtask : cfg_wr

  // one strobed access; outputs are settled just after the answering edge
  task automatic access_rw(input logic [23:0] a, input logic [2:0] fc, input logic u, input logic l,
                           input logic rd, input logic ds);
    @(posedge mclk);
    acc_addr  <= a;
    acc_fc    <= fc;
    acc_upper <= u;
    acc_lower <= l;
    acc_read  <= rd;
    as_pin    <= 1'b1;
    ds_pin    <= ds;
    @(posedge mclk);
    as_pin    <= 1'b0;
    ds_pin    <= 1'b0;
    #1;
  endtask : access_rw

  // read access strobed by the address strobe only
  task automatic access(input logic [23:0] a, input logic [2:0] fc, input logic u, input logic l);
    access_rw(a, fc, u, l, 1'b1, 1'b0);
  endtask : access

  // ----------------------------------------
  // clock, timeout and test sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    reset_n    = 1'b0;
    strap      = 8'h5a;
    cfg_write  = 1'b0;
    cfg_target = TGT_PIN;
    cfg_index  = 4'h0;
    cfg_data   = 16'h0000;
    acc_addr   = 24'h000000;
    acc_fc     = 3'h0;
    acc_read   = 1'b1;
    acc_upper  = 1'b0;
    acc_lower  = 1'b0;
    as_pin     = 1'b0;
    ds_pin     = 1'b0;
    do_reset(8'h5a);
    check_reset(8'h5a);
    repeat (5) @(posedge mclk);
    #1;
    chk({pin_high, pin_low}, exp_pins(8'h5a));
    $display("test reset_values done");
    access(24'h000000, FC_SUP_PROG, 1'b1, 1'b1);
    chk({sel, boot_sel}, 12'h001);
    access(24'h0ffffe, FC_SUP_PROG, 1'b1, 1'b0);
    chk(boot_sel, 1'b1);
    access(24'h100000, FC_SUP_PROG, 1'b1, 1'b1);
    chk(boot_sel, 1'b0);
    access(24'h000000, FC_CPU, 1'b1, 1'b1);
    chk(boot_sel, 1'b0);
    $display("test boot_decode done");
    cfg_wr(TGT_PIN, 4'h3, 16'h0003);
    cfg_wr(TGT_BASE, 4'h3, 16'h2000);
    cfg_wr(TGT_OPTION, 4'h3, 16'h7820);
    cfg_wr(TGT_OPTION, 4'hc, 16'hffff);
    chk(gen_opt[3], 16'h7820);
    chk(boot_opt, 16'h7b70);
    access(24'h200000, FC_SUP_PROG, 1'b0, 1'b1);
    chk(sel, 11'h008);
    access(24'h200800, FC_SUP_PROG, 1'b0, 1'b1);
    chk(sel, 11'h000);
    $display("test general_select done");
    cfg_wr(TGT_OPTION, 4'h3, 16'h6c20);
    access_rw(24'h200000, FC_SUP_PROG, 1'b0, 1'b1, 1'b1, 1'b0);
    chk(sel, 11'h000);
    access_rw(24'h200000, FC_SUP_PROG, 1'b0, 1'b1, 1'b1, 1'b1);
    chk(sel, 11'h008);
    access_rw(24'h200000, FC_SUP_PROG, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(sel, 11'h000);
    cfg_wr(TGT_OPTION, 4'h3, 16'h4c20);
    access_rw(24'h200000, FC_SUP_PROG, 1'b0, 1'b1, 1'b1, 1'b1);
    chk(sel, 11'h000);
    access_rw(24'h200000, FC_SUP_PROG, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(sel, 11'h008);
    cfg_wr(TGT_OPTION, 4'h3, 16'hcc20);
    access_rw(24'h200000, FC_SUP_PROG, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(sel, 11'h000);
    cfg_wr(TGT_OPTION, 4'h3, 16'h6804);
    access(24'h200004, FC_CPU, 1'b0, 1'b1);
    chk({sel, boot_sel}, 12'h010);
    access(24'h200006, FC_CPU, 1'b0, 1'b1);
    chk({sel, boot_sel}, 12'h000);
    $display("test select_attributes done");
    do_reset(8'ha5);
    check_reset(8'ha5);
    $display("test second_reset done");
    finish_test();
  end
endmodule : csr_chip_select_reset_config_bench
